// ### include/mem_monitor_pkg.sv
// shared constants and types for the memory soft-error monitor
package mem_monitor_pkg;
  localparam int unsigned NUM_MEMS       = 4;
  localparam int unsigned IDX_W          = 8;
  localparam int unsigned ADDR_W         = 16;
  // apb register offsets
  localparam logic [7:0] CTRL_OFF        = 8'h00;
  localparam logic [7:0] STAT_OFF        = 8'h04;
  localparam logic [7:0] INFO_OFF        = 8'h08;
  localparam logic [7:0] IDX_OFF         = 8'h0C;
  localparam logic [7:0] DIV_OFF         = 8'h10;
  localparam logic [7:0] RING_OFF        = 8'h14;
  // control fields
  localparam int unsigned CTRL_ACTIVATE  = 0;
  // status fields
  localparam int unsigned STAT_IDLE      = 0;
  localparam int unsigned STAT_DETECT    = 1;
  localparam int unsigned STAT_LISTEN    = 2;
  localparam int unsigned STAT_BUSY      = 3;
  localparam int unsigned STAT_INDIC     = 4;
  // info fields: flags in low nibble, address above
  localparam int unsigned INFO_UNCOR     = 0;
  localparam int unsigned INFO_UNCOR_OVF = 1;
  localparam int unsigned INFO_COR       = 2;
  localparam int unsigned INFO_COR_OVF   = 3;
  localparam int unsigned INFO_ADDR_LSB  = 16;
  // divider: reset value slow, software programs it lower
  localparam logic [7:0] DIV_RESET       = 8'hFF;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
  // memory index of the pcie mac memory that the ring bit gates
  localparam int unsigned PCIE_MEM       = NUM_MEMS - 1;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_CLEAR,
    CMD_POLL,
    CMD_FETCH
  } ring_cmd_e;
endpackage : mem_monitor_pkg

// ### include/mem_ring_if.sv
// link between the monitor and the per-memory detection wrappers
`timescale 1ns/1ps
interface mem_ring_if;
  logic                                        listen;
  mem_monitor_pkg::ring_cmd_e                  cmd;
  logic [mem_monitor_pkg::IDX_W-1:0]           cmd_idx;
  logic [mem_monitor_pkg::NUM_MEMS-1:0]        pending;
  logic [3:0]                                  rsp_flags;
  logic [mem_monitor_pkg::ADDR_W-1:0]          rsp_addr;

  modport monitor (output listen, output cmd, output cmd_idx,
                   input pending, input rsp_flags, input rsp_addr);
  modport memories (input listen, input cmd, input cmd_idx,
                    output pending, output rsp_flags, output rsp_addr);
endinterface : mem_ring_if

// ### hdl/mem_indication_slot.sv
// one memory's single indication slot: four flags and an address
`timescale 1ns/1ps
module mem_indication_slot (
  // clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // upset reports from the memory's ecc check, then listen and clear from the ring
  input  wire logic                                cor_err,
  input  wire logic                                uncor_err,
  input  wire logic [mem_monitor_pkg::ADDR_W-1:0]  err_addr,
  input  wire logic                                listen,
  input  wire logic                                clear,
  // stored indication
  output logic      [3:0]                          flags,
  output logic      [mem_monitor_pkg::ADDR_W-1:0]  addr
);
  logic [3:0]                         flags_reg;
  logic [3:0]                         flags_next;
  logic [mem_monitor_pkg::ADDR_W-1:0] addr_reg;
  logic [mem_monitor_pkg::ADDR_W-1:0] addr_next;
  logic                               addr_held;

  // an address is held by an uncorrectable, or by a correctable if no uncorrectable
  assign addr_held = flags_reg[mem_monitor_pkg::INFO_UNCOR] | flags_reg[mem_monitor_pkg::INFO_COR];

  always_comb begin
    flags_next = clear ? 4'h0 : flags_reg;
    addr_next  = clear ? '0 : addr_reg;
    // a new upset in the clear cycle still lands: set wins
    if (uncor_err) begin
      if (listen && !(flags_reg[mem_monitor_pkg::INFO_UNCOR] && !clear)) begin
        flags_next[mem_monitor_pkg::INFO_UNCOR] = 1'b1;
        flags_next[mem_monitor_pkg::INFO_COR]   = 1'b0;
        if (flags_reg[mem_monitor_pkg::INFO_COR] && !clear) begin
          flags_next[mem_monitor_pkg::INFO_COR_OVF] = 1'b1;
        end
        addr_next = err_addr;
      end else begin
        flags_next[mem_monitor_pkg::INFO_UNCOR_OVF] = 1'b1;
      end
    end else if (cor_err) begin
      if (listen && !(addr_held && !clear)) begin
        flags_next[mem_monitor_pkg::INFO_COR] = 1'b1;
        addr_next = err_addr;
      end else begin
        flags_next[mem_monitor_pkg::INFO_COR_OVF] = 1'b1;
      end
    end
  end

  // the array contents themselves are outside this slot and untouched by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= 4'h0;
      addr_reg  <= '0;
    end else begin
      flags_reg <= flags_next;
      addr_reg  <= addr_next;
    end
  end

  assign flags = flags_reg;
  assign addr  = addr_reg;
endmodule : mem_indication_slot

// ### hdl/mem_detect_ring.sv
// the memories' end: per-memory detection slots answering the monitor
`timescale 1ns/1ps
module mem_detect_ring (
  // clock and reset
  input  wire logic                                                   pclk,
  input  wire logic                                                   presetn,
  // link to the monitor
  mem_ring_if.memories                                                ring,
  // ecc reports, one lane per memory
  input  wire logic [mem_monitor_pkg::NUM_MEMS-1:0]                   cor_err,
  input  wire logic [mem_monitor_pkg::NUM_MEMS-1:0]                   uncor_err,
  input  wire logic [mem_monitor_pkg::NUM_MEMS-1:0][mem_monitor_pkg::ADDR_W-1:0] err_addr
);
  logic [mem_monitor_pkg::NUM_MEMS-1:0][3:0]                          flags;
  logic [mem_monitor_pkg::NUM_MEMS-1:0][mem_monitor_pkg::ADDR_W-1:0]  addr;
  logic [mem_monitor_pkg::NUM_MEMS-1:0]                               clr;

  for (genvar i = 0; i < mem_monitor_pkg::NUM_MEMS; i++) begin : g_mem
    // slots keep storing while idle; only the monitor's listen gates addresses
    assign clr[i] = (ring.cmd == mem_monitor_pkg::CMD_CLEAR) ||
                    (ring.cmd == mem_monitor_pkg::CMD_FETCH &&
                     ring.cmd_idx == mem_monitor_pkg::IDX_W'(i));
    mem_indication_slot u_slot (
      .pclk      (pclk),
      .presetn   (presetn),
      .cor_err   (cor_err[i]),
      .uncor_err (uncor_err[i]),
      .err_addr  (err_addr[i]),
      .listen    (ring.listen),
      .clear     (clr[i]),
      .flags     (flags[i]),
      .addr      (addr[i])
    );
    assign ring.pending[i] = |flags[i];
  end

  assign ring.rsp_flags = flags[ring.cmd_idx[1:0]];
  assign ring.rsp_addr  = addr[ring.cmd_idx[1:0]];
endmodule : mem_detect_ring

// ### hdl/mem_monitor.sv
// monitor end: idle/listen/detect state machine behind an apb register file
`timescale 1ns/1ps
module mem_monitor (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt to the main controller
  output logic             integrity_interrupt,
  // link to the memories
  mem_ring_if.monitor      ring
);
  typedef enum logic [1:0] {ST_IDLE, ST_LISTEN, ST_DETECT} mon_state_e;

  mon_state_e                          state_reg, state_next;
  mon_state_e                          target_reg, target_next;
  logic                                busy_reg, busy_next;
  logic                                first_reg, first_next;
  logic                                indic_reg, indic_next;
  logic [7:0]                          div_reg, div_next;
  logic [7:0]                          cnt_reg, cnt_next;
  logic                                ring_en_reg, ring_en_next;
  logic [3:0]                          info_flags_reg, info_flags_next;
  logic [mem_monitor_pkg::ADDR_W-1:0]  info_addr_reg, info_addr_next;
  logic [mem_monitor_pkg::IDX_W-1:0]   idx_reg, idx_next;
  logic [31:0]                         prdata_reg, prdata_next;
  logic                                pready_reg, pready_next;
  logic                                pslverr_reg, pslverr_next;
  logic                                irq_reg, irq_next;
  logic                                listen_reg, listen_next;
  mem_monitor_pkg::ring_cmd_e          cmd_reg, cmd_next;
  logic [mem_monitor_pkg::IDX_W-1:0]   cmd_idx_reg, cmd_idx_next;
  logic [mem_monitor_pkg::NUM_MEMS-1:0] seen;
  logic [mem_monitor_pkg::NUM_MEMS-1:0] rest;
  logic                                any_pending;
  logic [mem_monitor_pkg::IDX_W-1:0]   first_idx;
  logic                                wr_setup, rd_setup, act_wr;

  // pcie mac memory is masked unless its ring bit is set
  always_comb begin
    seen = ring.pending;
    seen[mem_monitor_pkg::PCIE_MEM] = ring.pending[mem_monitor_pkg::PCIE_MEM] & ring_en_reg;
    // the slot fetched on leaving detect is still pending here but must not count
    rest = seen;
    if (state_reg == ST_DETECT) begin
      rest[idx_reg[1:0]] = 1'b0;
    end
  end

  // lowest pending memory is read out first
  function automatic logic [mem_monitor_pkg::IDX_W-1:0] lowest(
    input logic [mem_monitor_pkg::NUM_MEMS-1:0] v);
    lowest = '0;
    for (int i = mem_monitor_pkg::NUM_MEMS - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = mem_monitor_pkg::IDX_W'(i);
      end
    end
  endfunction : lowest

  assign any_pending = |seen;
  assign first_idx   = lowest(seen);
  // registers answer in the first access cycle, so setup marks the single act
  assign wr_setup    = psel && !penable && pwrite;
  assign rd_setup    = psel && !penable && !pwrite;
  assign act_wr      = wr_setup && paddr == mem_monitor_pkg::CTRL_OFF &&
                       pwdata[mem_monitor_pkg::CTRL_ACTIVATE];

  // state machine and transitions
  always_comb begin
    state_next      = state_reg;
    target_next     = target_reg;
    busy_next       = busy_reg;
    first_next      = first_reg;
    indic_next      = indic_reg;
    cnt_next        = cnt_reg;
    info_flags_next = info_flags_reg;
    info_addr_next  = info_addr_reg;
    idx_next        = idx_reg;
    cmd_next        = mem_monitor_pkg::CMD_NONE;
    cmd_idx_next    = cmd_idx_reg;
    listen_next     = state_reg == ST_LISTEN;
    // activate writes while busy are ignored: one write, one advance
    if (act_wr && !busy_reg) begin
      busy_next = 1'b1;
      cnt_next  = div_reg;
      if (first_reg) begin
        target_next = ST_LISTEN;
        cmd_next    = mem_monitor_pkg::CMD_CLEAR;
        first_next  = 1'b0;
      end else if (state_reg == ST_LISTEN) begin
        target_next = ST_IDLE;
      end else if (|rest) begin
        target_next = ST_DETECT;
      end else begin
        target_next = ST_LISTEN;
      end
      if (state_reg == ST_DETECT) begin
        cmd_next     = mem_monitor_pkg::CMD_FETCH;
        cmd_idx_next = idx_reg;
      end
    end else if (busy_reg) begin
      // transition paced by the speed divider
      if (cnt_reg != 8'h00) begin
        cnt_next = cnt_reg - 8'h01;
      end else begin
        busy_next  = 1'b0;
        state_next = target_reg;
        if (target_reg == ST_DETECT) begin
          idx_next        = first_idx;
          info_flags_next = ring.rsp_flags;
          info_addr_next  = ring.rsp_addr;
        end
      end
    end
    // readout address for the detect capture
    if (busy_reg && target_reg == ST_DETECT) begin
      cmd_idx_next = first_idx;
    end
    // indication flag in listen, set beats clear
    if (state_reg == ST_LISTEN && any_pending) begin
      indic_next = 1'b1;
    end else if (wr_setup && paddr == mem_monitor_pkg::STAT_OFF &&
                 pwdata[mem_monitor_pkg::STAT_INDIC]) begin
      indic_next = 1'b0;
    end
  end

  // apb register file
  always_comb begin
    div_next     = div_reg;
    ring_en_next = ring_en_reg;
    prdata_next  = prdata_reg;
    pready_next  = psel && !penable;
    pslverr_next = 1'b0;
    irq_next     = indic_next;
    if (wr_setup) begin
      unique case (paddr)
        mem_monitor_pkg::DIV_OFF:  div_next     = pwdata[7:0];
        mem_monitor_pkg::RING_OFF: ring_en_next = pwdata[0];
        mem_monitor_pkg::CTRL_OFF,
        mem_monitor_pkg::STAT_OFF: ;
        default:                   pslverr_next = 1'b1;
      endcase
    end
    if (rd_setup) begin
      prdata_next = mem_monitor_pkg::UNMAPPED_DATA;
      unique case (paddr)
        mem_monitor_pkg::CTRL_OFF:
          prdata_next[mem_monitor_pkg::CTRL_ACTIVATE] = busy_reg;
        mem_monitor_pkg::STAT_OFF: begin
          prdata_next[mem_monitor_pkg::STAT_IDLE]   = state_reg == ST_IDLE;
          prdata_next[mem_monitor_pkg::STAT_DETECT] = state_reg == ST_DETECT;
          prdata_next[mem_monitor_pkg::STAT_LISTEN] = state_reg == ST_LISTEN;
          prdata_next[mem_monitor_pkg::STAT_BUSY]   = busy_reg;
          prdata_next[mem_monitor_pkg::STAT_INDIC]  = indic_reg;
        end
        mem_monitor_pkg::INFO_OFF: begin
          prdata_next[3:0] = info_flags_reg;
          prdata_next[mem_monitor_pkg::INFO_ADDR_LSB +: mem_monitor_pkg::ADDR_W] = info_addr_reg;
        end
        mem_monitor_pkg::IDX_OFF:  prdata_next[mem_monitor_pkg::IDX_W-1:0] = idx_reg;
        mem_monitor_pkg::DIV_OFF:  prdata_next[7:0] = div_reg;
        mem_monitor_pkg::RING_OFF: prdata_next[0] = ring_en_reg;
        default:                   pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      target_reg     <= ST_IDLE;
      busy_reg       <= 1'b0;
      first_reg      <= 1'b1;
      indic_reg      <= 1'b0;
      div_reg        <= mem_monitor_pkg::DIV_RESET;
      cnt_reg        <= 8'h00;
      ring_en_reg    <= 1'b0;
      info_flags_reg <= 4'h0;
      info_addr_reg  <= '0;
      idx_reg        <= '0;
      prdata_reg     <= 32'h0000_0000;
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      irq_reg        <= 1'b0;
      listen_reg     <= 1'b0;
      cmd_reg        <= mem_monitor_pkg::CMD_NONE;
      cmd_idx_reg    <= '0;
    end else begin
      state_reg      <= state_next;
      target_reg     <= target_next;
      busy_reg       <= busy_next;
      first_reg      <= first_next;
      indic_reg      <= indic_next;
      div_reg        <= div_next;
      cnt_reg        <= cnt_next;
      ring_en_reg    <= ring_en_next;
      info_flags_reg <= info_flags_next;
      info_addr_reg  <= info_addr_next;
      idx_reg        <= idx_next;
      prdata_reg     <= prdata_next;
      pready_reg     <= pready_next;
      pslverr_reg    <= pslverr_next;
      irq_reg        <= irq_next;
      listen_reg     <= listen_next;
      cmd_reg        <= cmd_next;
      cmd_idx_reg    <= cmd_idx_next;
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign integrity_interrupt = irq_reg;
  assign ring.listen         = listen_reg;
  assign ring.cmd            = cmd_reg;
  assign ring.cmd_idx        = cmd_idx_reg;
endmodule : mem_monitor

// ### test/mem_ring_asserts.sv
// link checks between the monitor and the memory detection ring
`timescale 1ns/1ps
module mem_ring_asserts (
  // clock and reset
  input wire logic                                 pclk,
  input wire logic                                 presetn,
  // link signals
  input wire logic                                 listen,
  input wire mem_monitor_pkg::ring_cmd_e           cmd,
  input wire logic [mem_monitor_pkg::IDX_W-1:0]    cmd_idx,
  input wire logic [mem_monitor_pkg::NUM_MEMS-1:0] pending,
  input wire logic [3:0]                           rsp_flags,
  input wire logic [mem_monitor_pkg::ADDR_W-1:0]   rsp_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       cleared_reg;
  logic       cleared_next;
  logic [1:0] sel;
  assign sel = cmd_idx[1:0];
  // listen is only legal once the slots were wiped after reset
  always_comb cleared_next = cleared_reg | (cmd == mem_monitor_pkg::CMD_CLEAR);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cleared_reg <= 1'b0;
    else cleared_reg <= cleared_next;
  end
  a_cmd_one_shot: assert property (
    cmd != mem_monitor_pkg::CMD_NONE |=> cmd == mem_monitor_pkg::CMD_NONE) else $error("cmd held");
  a_clear_then_listen: assert property (
    cmd == mem_monitor_pkg::CMD_CLEAR |=> pending == '0 ##[0:300] listen)
    else $error("clear did not empty slots and reach listen");
  a_idle_first: assert property (!cleared_reg |-> !listen) else $error("early listen");
  a_fetch_clears: assert property (
    cmd == mem_monitor_pkg::CMD_FETCH |=> !pending[$past(sel)]) else $error("slot not cleared");
  a_fetch_shown: assert property (
    cmd == mem_monitor_pkg::CMD_FETCH |-> pending[sel] && !listen) else $error("bad fetch");
  a_fetch_lowest: assert property (
    cmd == mem_monitor_pkg::CMD_FETCH |->
      (pending & ~({mem_monitor_pkg::NUM_MEMS{1'b1}} << sel)) == '0)
    else $error("fetch skipped a lower slot");
  a_addr_with_flag: assert property (
    !(rsp_flags[0] || rsp_flags[2]) |-> rsp_addr == '0) else $error("address kept without flag");
  a_uncor_wins: assert property (!(rsp_flags[0] && rsp_flags[2]))
    else $error("correctable kept beside uncorrectable");
  a_listen_steady: assert property ($rose(listen) |=> listen) else $error("listen glitch");
  c_clear: cover property (cmd == mem_monitor_pkg::CMD_CLEAR);
  c_fetch: cover property (cmd == mem_monitor_pkg::CMD_FETCH);
  c_listen: cover property ($rose(listen));
  c_overflow: cover property (rsp_flags[3] && rsp_addr != '0);
endmodule : mem_ring_asserts

// ### test/memory_soft_error_monitor_tb.sv
// self-checking bench: monitor and memory ring joined over their link
`timescale 1ns/1ps
module memory_soft_error_monitor_tb;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata;
  logic [3:0]       cor_err, uncor_err;
  logic [3:0][15:0] err_addr;
  int               num_errors = 0;
  int               samples_checked = 0;
  mem_ring_if ring ();
  mem_monitor i_mem_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .integrity_interrupt(irq), .ring(ring));
  mem_detect_ring i_mem_detect_ring (.pclk(pclk), .presetn(presetn), .ring(ring),
    .cor_err(cor_err), .uncor_err(uncor_err), .err_addr(err_addr));
  mem_ring_asserts i_mem_ring_asserts (.pclk(pclk), .presetn(presetn), .listen(ring.listen),
    .cmd(ring.cmd), .cmd_idx(ring.cmd_idx), .pending(ring.pending),
    .rsp_flags(ring.rsp_flags), .rsp_addr(ring.rsp_addr));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // entered just after a rising edge; one idle cycle after each transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check("pready timeout", 32'h0, 32'h1);
      close_out();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q & mask, exp);
  endtask : rd_chk
  task automatic settle(input logic [31:0] mode);
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, mem_monitor_pkg::STAT_OFF, 32'h0, q, e);
      n++;
    end while (q[mem_monitor_pkg::STAT_BUSY] !== 1'b0 && n < 100);
    if (q[mem_monitor_pkg::STAT_BUSY] !== 1'b0) begin
      check("busy timeout", 32'h0, 32'h1);
      close_out();
    end else begin
      check("state flags", q & 32'h7, mode);
    end
  endtask : settle
  task automatic step(input logic [31:0] mode);
    wr(mem_monitor_pkg::CTRL_OFF, 32'h1);
    settle(mode);
  endtask : step
  task automatic upset(input int m, input logic unc, input logic [15:0] a);
    cor_err[m] <= !unc;
    uncor_err[m] <= unc;
    err_addr[m] <= a;
    @(posedge pclk);
    cor_err <= 4'h0;
    uncor_err <= 4'h0;
    @(posedge pclk);
  endtask : upset
  task automatic detect(input logic [31:0] idx, input logic [31:0] info);
    step(32'h2);
    rd_chk("index", mem_monitor_pkg::IDX_OFF, idx, 32'hFF);
    rd_chk("info", mem_monitor_pkg::INFO_OFF, info, 32'hFFFF_000F);
  endtask : detect
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd_chk("status", mem_monitor_pkg::STAT_OFF, 32'h1, 32'h1F);
    rd_chk("divider", mem_monitor_pkg::DIV_OFF, 32'hFF, 32'hFF);
    rd_chk("activate", mem_monitor_pkg::CTRL_OFF, 32'h0, 32'h1);
    apb(1'b0, 8'h1C, 32'h0, q, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", q, mem_monitor_pkg::UNMAPPED_DATA);
    $display("test reset done");
  endtask : t_reset
  task automatic t_first();
    // a slow divider keeps busy long enough to be read back
    wr(mem_monitor_pkg::DIV_OFF, 32'h8);
    upset(0, 1'b0, 16'h0011);
    check("irq idle", {31'h0, irq}, 32'h0);
    wr(mem_monitor_pkg::CTRL_OFF, 32'h1);
    wr(mem_monitor_pkg::CTRL_OFF, 32'h1);
    rd_chk("activate busy", mem_monitor_pkg::CTRL_OFF, 32'h1, 32'h1);
    rd_chk("busy", mem_monitor_pkg::STAT_OFF, 32'h8, 32'h8);
    settle(32'h4);
    rd_chk("activate done", mem_monitor_pkg::CTRL_OFF, 32'h0, 32'h1);
    rd_chk("no indication", mem_monitor_pkg::STAT_OFF, 32'h0, 32'h10);
    $display("test first activate done");
  endtask : t_first
  task automatic t_listen();
    upset(1, 1'b1, 16'h1234);
    upset(1, 1'b1, 16'h2222);
    upset(2, 1'b0, 16'hBEEF);
    upset(2, 1'b1, 16'h5555);
    upset(0, 1'b0, 16'h00C1);
    upset(0, 1'b0, 16'h00C2);
    upset(3, 1'b0, 16'h0AAA);
    rd_chk("indication", mem_monitor_pkg::STAT_OFF, 32'h10, 32'h10);
    check("irq", {31'h0, irq}, 32'h1);
    $display("test listen done");
  endtask : t_listen
  task automatic t_readout();
    step(32'h1);
    detect(32'h0, 32'h00C1_000C);
    detect(32'h1, 32'h1234_0003);
    detect(32'h2, 32'h5555_0009);
    step(32'h4);
    wr(mem_monitor_pkg::RING_OFF, 32'h1);
    step(32'h1);
    detect(32'h3, 32'h0AAA_0004);
    step(32'h4);
    step(32'h1);
    upset(0, 1'b0, 16'h7777);
    detect(32'h0, 32'h0000_0008);
    step(32'h4);
    wr(mem_monitor_pkg::STAT_OFF, 32'h10);
    rd_chk("indication cleared", mem_monitor_pkg::STAT_OFF, 32'h0, 32'h10);
    check("irq cleared", {31'h0, irq}, 32'h0);
    $display("test readout done");
  endtask : t_readout
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cor_err = 4'h0;
    uncor_err = 4'h0;
    err_addr = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_first();
    t_listen();
    t_readout();
    close_out();
  end
endmodule : memory_soft_error_monitor_tb
